// ==== bcg_top.sv ====
/*
  Branch clock gating unit: AXI4-Lite register file, power-down and wake-up
  control, and one gate per branch clock.
  Assumes base clocks arrive from the clock generator much slower than CLK_IN,
  and that masters answer the disable request on MDIS_ACK_IN.
*/
// Overview of operation
// [R01] Each branch clock is switched by bits in its own configuration register.
// [R02] Branches for vital functions have some mode bits fixed by hardware.
// [R03] A bit tied high reads 1 and ignores writes; run bit of five branches.
// [R04] A bit tied low reads 0 and ignores writes; safe branch wake and auto.
// [R05] Untied mode bits (wake-up, auto, run) are readable and writable.
// [R06] A wake-up event restarts sleeping branches enabled for wake-up.
// [R07] Setting power-down stops branches configured to stop on power-down entry.
// [R08] While power-down is set, wake-up restarts are held off.
// [R09] Auto branches complete the master-disable handshake before their clock stops.
// [R10] A per-base status bit shows when all its branches are off.
// [R11] Each branch is fixed to one base clock, with no source selection.
// [R12] Branches of one base keep frequency and phase; gating drops whole cycles.
// [R13] Software idles the processor by stopping its branch, not by standby; here processor_branch has its run bit tied high.
// [R14] Software ensures the base clock runs before re-enabling a branch.
// [R15] A gate opens or closes only while its base clock is low.
`timescale 1ns/1ps
module bcg_top (
  // Clock and reset.
  input  wire logic                                  CLK_IN,
  input  wire logic                                  RESETN_IN,
  // AXI4-Lite write channels.
  input  wire logic [bcg_pkg::ADDR_W-1:0]            S_AXI_AWADDR_IN,
  input  wire logic                                  S_AXI_AWVALID_IN,
  output logic                                       S_AXI_AWREADY_OUT,
  input  wire logic [bcg_pkg::DATA_W-1:0]            S_AXI_WDATA_IN,
  input  wire logic [3:0]                            S_AXI_WSTRB_IN,
  input  wire logic                                  S_AXI_WVALID_IN,
  output logic                                       S_AXI_WREADY_OUT,
  output logic [1:0]                                 S_AXI_BRESP_OUT,
  output logic                                       S_AXI_BVALID_OUT,
  input  wire logic                                  S_AXI_BREADY_IN,
  // AXI4-Lite read channels.
  input  wire logic [bcg_pkg::ADDR_W-1:0]            S_AXI_ARADDR_IN,
  input  wire logic                                  S_AXI_ARVALID_IN,
  output logic                                       S_AXI_ARREADY_OUT,
  output logic [bcg_pkg::DATA_W-1:0]                 S_AXI_RDATA_OUT,
  output logic [1:0]                                 S_AXI_RRESP_OUT,
  output logic                                       S_AXI_RVALID_OUT,
  input  wire logic                                  S_AXI_RREADY_IN,
  // Clock generator side.
  input  wire logic [bcg_pkg::NUM_BASE-1:0]          BASE_CLK_IN,
  input  wire logic                                  WAKE_EVENT_IN,
  // Sub-module side.
  input  wire logic [bcg_pkg::NUM_BRANCH-1:0]        MDIS_ACK_IN,
  output logic      [bcg_pkg::NUM_BRANCH-1:0]        BRANCH_CLK_OUT,
  output logic      [bcg_pkg::NUM_BRANCH-1:0]        MDIS_REQ_OUT
);

  localparam int NB = bcg_pkg::NUM_BRANCH;

  typedef struct packed {
    logic                              aw_held;
    logic [bcg_pkg::ADDR_W-1:0]        awaddr;
    logic                              w_held;
    logic [bcg_pkg::DATA_W-1:0]        wdata;
    logic [3:0]                        wstrb;
    logic                              awready;
    logic                              wready;
    logic                              bvalid;
    logic [1:0]                        bresp;
    logic                              arready;
    logic                              rvalid;
    logic [bcg_pkg::DATA_W-1:0]        rdata;
    logic [1:0]                        rresp;
    logic                              pd;
    logic                              wake_pend;
    logic                              wake_prev;
    logic [NB-1:0]                     sleep;
    logic [NB-1:0][bcg_pkg::CFG_W-1:0] cfg;
  } bcg_top_state_t;

  bcg_top_state_t s;
  bcg_top_state_t n;

  logic                          rst_meta_ff;
  logic                          rst_n_ff;
  logic [bcg_pkg::NUM_BASE-1:0]  base_sync;
  logic                          wake_sync;
  logic [NB-1:0]                 ack_sync;
  logic [NB-1:0]                 running;
  logic [NB-1:0]                 want_on;
  logic [NB-1:0]                 wake_mask;
  logic [bcg_pkg::NUM_BASE-1:0]  base_off;

  // Forces tied bits whatever software writes.
  function automatic logic [bcg_pkg::CFG_W-1:0] apply_ties(
    input int                        idx,
    input logic [bcg_pkg::CFG_W-1:0] v
  );
    logic [bcg_pkg::CFG_W-1:0] r;
    r = v;
    if (bcg_pkg::RUN_TIE1[idx])
      r[bcg_pkg::CFG_RUN_BIT] = 1'b1; // [R02] [R03]
    if (bcg_pkg::WAKE_TIE0[idx])
      r[bcg_pkg::CFG_WAKE_BIT] = 1'b0; // [R02] [R04]
    if (bcg_pkg::AUTO_TIE0[idx])
      r[bcg_pkg::CFG_AUTO_BIT] = 1'b0; // [R04]
    return r;
  endfunction : apply_ties

  function automatic logic is_cfg(input logic [bcg_pkg::ADDR_W-1:0] a);
    return (a >= bcg_pkg::REG_CFG0) && (a <= bcg_pkg::REG_CFG_LAST) && (a[1:0] == 2'h0);
  endfunction : is_cfg

  function automatic int cfg_index(input logic [bcg_pkg::ADDR_W-1:0] a);
    logic [bcg_pkg::ADDR_W-1:0] off;
    off = a - bcg_pkg::REG_CFG0;
    return int'(off[bcg_pkg::ADDR_W-1:2]);
  endfunction : cfg_index

  function automatic logic addr_ok(input logic [bcg_pkg::ADDR_W-1:0] a);
    return is_cfg(a) || (a == bcg_pkg::REG_PWR) || (a == bcg_pkg::REG_BASE_OFF)
           || (a == bcg_pkg::REG_RUNNING);
  endfunction : addr_ok

  // Reset release through two flip-flops.
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  bcg_sync #(.W(bcg_pkg::NUM_BASE)) u_base_sync (
    .clk_in   (CLK_IN),
    .rst_n_in (rst_n_ff),
    .d_in     (BASE_CLK_IN),
    .q_out    (base_sync)
  );

  bcg_sync #(.W(1)) u_wake_sync (
    .clk_in   (CLK_IN),
    .rst_n_in (rst_n_ff),
    .d_in     (WAKE_EVENT_IN),
    .q_out    (wake_sync)
  );

  bcg_sync #(.W(NB)) u_ack_sync (
    .clk_in   (CLK_IN),
    .rst_n_in (rst_n_ff),
    .d_in     (MDIS_ACK_IN),
    .q_out    (ack_sync)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++)
    begin : g_branch
      // The base is a fixed constant per branch; no selector exists.
      bcg_branch_gate u_gate (
        .clk_in         (CLK_IN),
        .rst_n_in       (rst_n_ff),
        .base_clk_in    (base_sync[bcg_pkg::BASE_MAP[gi]]), // [R11]
        .want_on_in     (want_on[gi]),
        .auto_en_in     (s.cfg[gi][bcg_pkg::CFG_AUTO_BIT]),
        .mdis_ack_in    (ack_sync[gi]),
        .branch_clk_out (BRANCH_CLK_OUT[gi]),
        .mdis_req_out   (MDIS_REQ_OUT[gi]),
        .running_out    (running[gi])
      );
    end
  endgenerate

  always_comb
  begin
    base_off = '1;
    for (int i = 0; i < NB; i++)
    begin
      want_on[i]   = s.cfg[i][bcg_pkg::CFG_RUN_BIT] & ~s.sleep[i]; // [R01]
      wake_mask[i] = s.cfg[i][bcg_pkg::CFG_WAKE_BIT];
      if (running[i])
        base_off[bcg_pkg::BASE_MAP[i]] = 1'b0; // [R10]
    end
  end

  always_comb
  begin
    logic [bcg_pkg::DATA_W-1:0] rd;
    int                         idx;
    rd          = '0;
    idx         = 0;
    n           = s;
    n.wake_prev = wake_sync;

    // Restart is taken only once power-down has cleared.
    if (s.wake_pend && !s.pd)
    begin
      n.sleep     = s.sleep & ~wake_mask; // [R06] [R08]
      n.wake_pend = 1'b0;
    end

    if (s.awready && S_AXI_AWVALID_IN)
    begin
      n.aw_held = 1'b1;
      n.awaddr  = S_AXI_AWADDR_IN;
    end
    if (s.wready && S_AXI_WVALID_IN)
    begin
      n.w_held = 1'b1;
      n.wdata  = S_AXI_WDATA_IN;
      n.wstrb  = S_AXI_WSTRB_IN;
    end
    if (s.bvalid && S_AXI_BREADY_IN)
      n.bvalid = 1'b0;

    if (s.aw_held && s.w_held && !s.bvalid)
    begin
      n.aw_held = 1'b0;
      n.w_held  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = addr_ok(s.awaddr) ? bcg_pkg::RESP_OKAY : bcg_pkg::RESP_SLVERR;
      // Only byte lane 0 holds control bits; other lanes are ignored.
      if (s.wstrb[0])
      begin
        if (s.awaddr == bcg_pkg::REG_PWR)
        begin
          n.pd = s.wdata[bcg_pkg::PWR_PD_BIT];
          if (s.wdata[bcg_pkg::PWR_PD_BIT] && !s.pd)
            n.sleep = n.sleep | wake_mask; // [R07]
        end
        else if (is_cfg(s.awaddr))
        begin
          idx        = cfg_index(s.awaddr);
          n.cfg[idx] = apply_ties(idx, s.wdata[bcg_pkg::CFG_W-1:0]); // [R01] [R05]
        end
      end
    end

    // A wake-up event ends power-down; it wins over a software write that cycle.
    if (wake_sync && !s.wake_prev)
    begin
      n.wake_pend = 1'b1; // [R06]
      n.pd        = 1'b0;
    end

    if (s.rvalid && S_AXI_RREADY_IN)
      n.rvalid = 1'b0;
    if (s.arready && S_AXI_ARVALID_IN)
    begin
      if (S_AXI_ARADDR_IN == bcg_pkg::REG_PWR)
        rd[bcg_pkg::PWR_PD_BIT] = s.pd;
      else if (S_AXI_ARADDR_IN == bcg_pkg::REG_BASE_OFF)
        rd[bcg_pkg::NUM_BASE-1:0] = base_off; // [R10]
      else if (S_AXI_ARADDR_IN == bcg_pkg::REG_RUNNING)
        rd[NB-1:0] = running;
      else if (is_cfg(S_AXI_ARADDR_IN))
        rd[bcg_pkg::CFG_W-1:0] = s.cfg[cfg_index(S_AXI_ARADDR_IN)]; // [R03] [R04] [R05]
      n.rvalid = 1'b1;
      n.rdata  = rd;
      n.rresp  = addr_ok(S_AXI_ARADDR_IN) ? bcg_pkg::RESP_OKAY : bcg_pkg::RESP_SLVERR;
    end

    // One write and one read in flight; ready falls while an answer is pending.
    n.awready = !n.aw_held && !n.bvalid;
    n.wready  = !n.w_held && !n.bvalid;
    n.arready = !n.rvalid;
  end

  always_ff @(posedge CLK_IN or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      s         <= '0;
      s.awready <= 1'b1;
      s.wready  <= 1'b1;
      s.arready <= 1'b1;
      for (int i = 0; i < NB; i++)
        s.cfg[i] <= bcg_pkg::CFG_RESET;
    end
    else
      s <= n;
  end

  assign S_AXI_AWREADY_OUT = s.awready;
  assign S_AXI_WREADY_OUT  = s.wready;
  assign S_AXI_BVALID_OUT  = s.bvalid;
  assign S_AXI_BRESP_OUT   = s.bresp;
  assign S_AXI_ARREADY_OUT = s.arready;
  assign S_AXI_RVALID_OUT  = s.rvalid;
  assign S_AXI_RDATA_OUT   = s.rdata;
  assign S_AXI_RRESP_OUT   = s.rresp;

endmodule : bcg_top

// ==== bcg_pkg.sv ====
/*
  Shared constants and types for the branch clock gating unit.
  Assumes a single system clock and a 32-bit AXI4-Lite register bus.
*/
package bcg_pkg;

  localparam int NUM_BRANCH = 8;
  localparam int NUM_BASE   = 4;
  localparam int BASE_W     = 2;
  localparam int CFG_W      = 3;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;

  // Configuration bit positions inside one branch register, and the power-down bit of the power register.
  localparam int CFG_RUN_BIT  = 0;
  localparam int CFG_AUTO_BIT = 1;
  localparam int CFG_WAKE_BIT = 2;
  localparam int PWR_PD_BIT   = 0;

  // Every branch leaves reset running, without wake-up or automatic gating.
  localparam logic [CFG_W-1:0] CFG_RESET = 3'h1;

  // Branch order: 0 safe, 1 processor_branch, 2 system, 3 clock_control_system_branch,
  // 4 flash controller, 5 clock_control_slow_branch, 6 uart0, 7 uart1.
  localparam logic [NUM_BRANCH-1:0] RUN_TIE1  = 8'h2f;
  localparam logic [NUM_BRANCH-1:0] WAKE_TIE0 = 8'h01;
  localparam logic [NUM_BRANCH-1:0] AUTO_TIE0 = 8'h01;

  // Base clock of each branch: 0 safe, 1 system_base_clock, 2 clock control, 3 peripheral.
  localparam logic [NUM_BRANCH-1:0][BASE_W-1:0] BASE_MAP = 16'hf954;

  // Register byte addresses.
  localparam logic [ADDR_W-1:0] REG_PWR      = 8'h00;
  localparam logic [ADDR_W-1:0] REG_BASE_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] REG_RUNNING  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CFG0     = 8'h10;
  localparam logic [ADDR_W-1:0] REG_CFG_LAST = 8'h2c;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {GATE_ON, GATE_HANDSHAKE, GATE_OFF} bcg_gate_state_t;

endpackage : bcg_pkg

// ==== bcg_sync.sv ====
/*
  Two flip-flop synchroniser for levels entering the system clock domain.
  Assumes the input changes slower than the clock can sample it.
*/
`timescale 1ns/1ps
module bcg_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } bcg_sync_state_t;

  bcg_sync_state_t s;
  bcg_sync_state_t n;

  always_comb
  begin
    n        = s;
    n.meta   = d_in;
    n.stable = s.meta;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      s <= '0;
    else
      s <= n;
  end

  assign q_out = s.stable;

endmodule : bcg_sync

// ==== bcg_branch_gate.sv ====
/*
  Gate for one branch clock, with the optional master-disable handshake.
  Assumes the base clock and acknowledge are already synchronised.
*/
`timescale 1ns/1ps
module bcg_branch_gate (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic base_clk_in,
  input  wire logic want_on_in,
  input  wire logic auto_en_in,
  input  wire logic mdis_ack_in,
  output logic      branch_clk_out,
  output logic      mdis_req_out,
  output logic      running_out
);

  typedef struct packed {
    bcg_pkg::bcg_gate_state_t state;
    logic                     gate_en;
    logic                     clk;
    logic                     req;
  } bcg_gate_t;

  bcg_gate_t s;
  bcg_gate_t n;

  always_comb
  begin
    n     = s;
    // All branches of one base share this pipeline, so their phase stays aligned.
    n.clk = base_clk_in & s.gate_en; // [R12]
    unique case (s.state)
      bcg_pkg::GATE_ON:
        if (!want_on_in)
        begin
          if (auto_en_in)
          begin
            n.state = bcg_pkg::GATE_HANDSHAKE; // [R09]
            n.req   = 1'b1;
          end
          else if (!base_clk_in)
          begin
            n.gate_en = 1'b0; // [R15]
            n.state   = bcg_pkg::GATE_OFF;
          end
        end
      bcg_pkg::GATE_HANDSHAKE:
        if (want_on_in)
        begin
          n.state = bcg_pkg::GATE_ON;
          n.req   = 1'b0;
        end
        else if (mdis_ack_in && !base_clk_in)
        begin
          n.gate_en = 1'b0; // [R09] [R15]
          n.state   = bcg_pkg::GATE_OFF;
        end
      bcg_pkg::GATE_OFF:
        if (want_on_in && !base_clk_in)
        begin
          n.gate_en = 1'b1; // [R15]
          n.state   = bcg_pkg::GATE_ON;
          n.req     = 1'b0;
        end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s.state   <= bcg_pkg::GATE_ON;
      s.gate_en <= 1'b1;
      s.clk     <= 1'b0;
      s.req     <= 1'b0;
    end
    else
      s <= n;
  end

  assign branch_clk_out = s.clk;
  assign mdis_req_out   = s.req;
  assign running_out    = (s.state != bcg_pkg::GATE_OFF);

endmodule : bcg_branch_gate

// ==== bcg_cgu_model.sv ====
/*
  Model of the clock generator and of the bus masters behind the branches.
  Assumes it shares the system clock and reset of the gating unit.
*/
`timescale 1ns/1ps
module bcg_cgu_model (
  // Clock and reset.
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Acknowledge speed, high for late masters.
  input  wire logic       slow_in,
  // Gating unit side.
  input  wire logic [7:0] mdis_req_in,
  output logic      [3:0] base_clk_out,
  output logic      [7:0] mdis_ack_out
);
  logic [4:0]      cnt_ff;
  logic [5:0][7:0] req_ff;

  // Base clocks run free, so a branch may be reopened at any time.
  assign base_clk_out = {cnt_ff[4], cnt_ff[2], cnt_ff[3], cnt_ff[2]};
  // A master drops its acknowledge as soon as the request goes away.
  assign mdis_ack_out = (slow_in ? req_ff[5] : req_ff[0]) & mdis_req_in;

  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      cnt_ff <= 5'h0;
      req_ff <= 48'h0;
    end
    else
    begin
      cnt_ff <= cnt_ff + 5'h1;
      req_ff <= {req_ff[4:0], mdis_req_in};
    end
endmodule : bcg_cgu_model

// ==== bcg_checker.sv ====
/*
  Assertions on the ports of the branch clock gating unit.
  Assumes base clocks reach the branch outputs three CLK_IN edges late.
*/
`timescale 1ns/1ps
module bcg_checker (
  // Clock and reset.
  input  wire logic        CLK_IN,
  input  wire logic        RESETN_IN,
  // Register bus.
  input  wire logic        S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  input  wire logic [1:0]  S_AXI_BRESP_OUT,
  input  wire logic        S_AXI_ARREADY_OUT,
  input  wire logic        S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN,
  input  wire logic [31:0] S_AXI_RDATA_OUT,
  // Clocks and handshake.
  input  wire logic [3:0]  BASE_CLK_IN,
  input  wire logic [7:0]  MDIS_ACK_IN,
  input  wire logic [7:0]  BRANCH_CLK_OUT,
  input  wire logic [7:0]  MDIS_REQ_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  // The safe branch is judged only once the delayed reset release has settled.
  logic [2:0] settle_ff;
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
      settle_ff <= 3'h0;
    else if (settle_ff != 3'h7)
      settle_ff <= settle_ff + 3'h1;

  property p_bvalid_hold;
    S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("Write response dropped before it was taken.");
  property p_rvalid_hold;
    S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold)
    else $error("Read data changed before it was taken.");
  property p_read_refused;
    S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT;
  endproperty
  a_read_refused: assert property (p_read_refused)
    else $error("Read address accepted while a read was pending.");
  property p_safe;
    settle_ff == 3'h7 |-> BRANCH_CLK_OUT[0] == $past(BASE_CLK_IN[0], 3);
  endproperty
  a_safe: assert property (p_safe)
    else $error("Safe branch clock did not follow its base clock.");
  property p_safe_no_req;
    !MDIS_REQ_OUT[0];
  endproperty
  a_safe_no_req: assert property (p_safe_no_req)
    else $error("Safe branch raised a disable request.");

  for (genvar i = 0; i < 8; i++)
  begin : g_br
    localparam int B = bcg_pkg::BASE_MAP[i];
    sequence s_passes;
      BRANCH_CLK_OUT[i] == $past(BASE_CLK_IN[B], 3);
    endsequence
    property p_follow;
      BRANCH_CLK_OUT[i] |-> $past(BASE_CLK_IN[B], 3);
    endproperty
    a_follow: assert property (p_follow)
      else $error("Branch clock high without its base clock.");
    property p_glitch;
      $fell(BRANCH_CLK_OUT[i]) |-> !$past(BASE_CLK_IN[B], 3);
    endproperty
    a_glitch: assert property (p_glitch)
      else $error("Branch clock pulse cut short.");
    property p_hold;
      $rose(MDIS_REQ_OUT[i]) && !MDIS_ACK_IN[i] |-> s_passes [*3];
    endproperty
    a_hold: assert property (p_hold)
      else $error("Branch clock stopped before the acknowledge.");
  end
endmodule : bcg_checker

bind bcg_top bcg_checker u_chk (.CLK_IN, .RESETN_IN, .S_AXI_BVALID_OUT, .S_AXI_BREADY_IN,
  .S_AXI_BRESP_OUT, .S_AXI_ARREADY_OUT, .S_AXI_RVALID_OUT, .S_AXI_RREADY_IN,
  .S_AXI_RDATA_OUT, .BASE_CLK_IN, .MDIS_ACK_IN, .BRANCH_CLK_OUT, .MDIS_REQ_OUT);

// ==== testbench.sv ====
/*
  Self-checking bench for the branch clock gating unit over AXI4-Lite.
  Assumes the clock generator model supplies base clocks and acknowledges.
*/
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] CFG4 = bcg_pkg::REG_CFG0 + 8'h10;
  localparam logic [7:0] CFG6 = bcg_pkg::REG_CFG0 + 8'h18;
  localparam logic [7:0] CFG7 = bcg_pkg::REG_CFG0 + 8'h1c;
  localparam logic [1:0] OK   = bcg_pkg::RESP_OKAY;
  logic        clk = 1'b0;
  logic        rstn;
  logic [7:0]  awaddr, araddr, a;
  logic [31:0] wdata, rdata, q;
  logic        awvalid, wvalid, bready, arvalid, rready, wake, slow;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rs;
  logic [3:0]  base;
  logic [7:0]  ack, bclk, req;
  int          failures = 0;
  int          checked = 0;
  int          i;

  always #50 clk = ~clk;

  bcg_top DUT (
    .CLK_IN(clk), .RESETN_IN(rstn),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
    .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
    .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
    .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
    .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .BASE_CLK_IN(base),
    .WAKE_EVENT_IN(wake), .MDIS_ACK_IN(ack), .BRANCH_CLK_OUT(bclk), .MDIS_REQ_OUT(req));
  bcg_cgu_model u_cgu (.clk_in(clk), .rst_n_in(rstn), .slow_in(slow), .mdis_req_in(req),
    .base_clk_out(base), .mdis_ack_out(ack));

  task complete_run;
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One transfer; each channel is released at the edge that takes it.
  task bus(input logic w, input logic [7:0] ad, input logic [31:0] d,
           output logic [31:0] tq, output logic [1:0] ts);
    logic got;
    @(posedge clk);
    awaddr <= ad; araddr <= ad; wdata <= d;
    awvalid <= w; wvalid <= w; bready <= w; arvalid <= !w; rready <= !w;
    got = 1'b0;
    tq = 32'h0;
    ts = 2'h0;
    for (int n = 0; n < 200 && !got; n++)
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
      if (w ? bvalid : rvalid)
      begin
        got = 1'b1;
        tq = rdata;
        ts = w ? bresp : rresp;
        bready <= 1'b0;
        rready <= 1'b0;
      end
    end
    if (!got)
    begin
      $display("Error at %0t ns: bus timeout", $time);
      failures++;
      complete_run;
    end
  endtask : bus

  task wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] e);
    logic [31:0] tq;
    logic [1:0]  ts;
    bus(1'b1, ad, d, tq, ts);
    check(32'(ts), 32'(e));
  endtask : wr

  task rd_chk(input logic [7:0] ad, input logic [31:0] e);
    logic [31:0] tq;
    logic [1:0]  ts;
    bus(1'b0, ad, 32'h0, tq, ts);
    check(tq, e);
  endtask : rd_chk

  // Status bits settle a few base periods after a change.
  task poll(input logic [7:0] ad, input logic [31:0] e);
    logic [31:0] tq;
    logic [1:0]  ts;
    for (int k = 0; k < 40; k++)
    begin
      bus(1'b0, ad, 32'h0, tq, ts);
      if (tq === e) break;
    end
    check(tq, e);
  endtask : poll

  initial
  begin
    repeat (20000) @(posedge clk);
    $display("Error at %0t ns: run timeout", $time);
    failures++;
    complete_run;
  end

  initial
  begin
    rstn = 1'b0; awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0; awvalid = 1'b0;
    wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0; wake = 1'b0; slow = 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    for (i = 0; i < 8; i++)
      rd_chk(bcg_pkg::REG_CFG0 + 8'(4 * i), 32'(bcg_pkg::CFG_RESET));
    rd_chk(bcg_pkg::REG_PWR, 32'h0);
    rd_chk(bcg_pkg::REG_RUNNING, 32'hff);
    rd_chk(bcg_pkg::REG_BASE_OFF, 32'h0);
    bus(1'b0, 8'h80, 32'h0, q, rs);
    check(q, 32'h0);
    check(32'(rs), 32'(bcg_pkg::RESP_SLVERR));
    wr(8'h80, 32'h7, bcg_pkg::RESP_SLVERR);
    wr(bcg_pkg::REG_RUNNING, 32'h0, OK);
    for (i = 0; i < 8; i++)
    begin
      a = bcg_pkg::REG_CFG0 + 8'(4 * i);
      wr(a, 32'h7, OK);
      rd_chk(a, {29'h0, ~bcg_pkg::WAKE_TIE0[i], ~bcg_pkg::AUTO_TIE0[i], 1'b1});
      // The processor branch keeps running after this write; its run bit is tied high.
      wr(a, 32'h0, OK);
      rd_chk(a, {31'h0, bcg_pkg::RUN_TIE1[i]});
    end
    poll(bcg_pkg::REG_RUNNING, {24'h0, bcg_pkg::RUN_TIE1});
    poll(bcg_pkg::REG_BASE_OFF, 32'h8);
    repeat (20) @(posedge clk) check(32'(bclk[7:6]), 32'h0);
    for (i = 0; i < 2; i++)
    begin
      slow <= i[0];
      wr(CFG6, 32'h3, OK);
      poll(bcg_pkg::REG_RUNNING, 32'h6f);
      wr(CFG6, 32'h2, OK);
      for (int k = 0; k < 20 && req[6] !== 1'b1; k++) @(posedge clk);
      check(32'(req[6]), 32'h1);
      if (i == 1) rd_chk(bcg_pkg::REG_RUNNING, 32'h6f);
      poll(bcg_pkg::REG_RUNNING, 32'h2f);
      check(32'(req[6]), 32'h1);
    end
    wr(CFG4, 32'h5, OK);
    wr(CFG7, 32'h1, OK);
    poll(bcg_pkg::REG_RUNNING, 32'hbf);
    wr(bcg_pkg::REG_PWR, 32'h1, OK);
    poll(bcg_pkg::REG_RUNNING, 32'haf);
    rd_chk(bcg_pkg::REG_PWR, 32'h1);
    rd_chk(bcg_pkg::REG_RUNNING, 32'haf);
    wake <= 1'b1;
    repeat (4) @(posedge clk);
    wake <= 1'b0;
    poll(bcg_pkg::REG_RUNNING, 32'hbf);
    rd_chk(bcg_pkg::REG_PWR, 32'h0);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(CFG4, 32'(bcg_pkg::CFG_RESET));
    complete_run;
  end
endmodule : testbench
